// ### verilog/bur_pkg.sv
package bur_pkg;

   // ----------------------------------------
   // character framing
   // ----------------------------------------
   localparam int DATA_BITS = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_START = 1'b0;

   // ----------------------------------------
   // defaults
   // ----------------------------------------
   localparam int CLOCK_HZ_DEFAULT = 10_000_000;
   localparam int BAUD_DEFAULT = 115_200;
   localparam int FIFO_DEPTH_DEFAULT = 2048;

   // ----------------------------------------
   // serial phase, shared by receiver and transmitter
   // ----------------------------------------
   typedef enum logic [3:0] {
      BUR_IDLE = 4'h1,
      BUR_START = 4'h2,
      BUR_DATA = 4'h4,
      BUR_STOP = 4'h8
   } bur_phase_t;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_INT_STATUS = 8'h04;
   localparam logic [7:0] REG_INT_MASK = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // status bits
   localparam int ST_RX_FULL = 0;
   localparam int ST_STOP_ERR = 1;
   localparam int ST_RX_AVAIL = 2;
   localparam int ST_TX_EMPTY = 3;
   localparam int ST_TX_BUSY = 4;

   // event bits, shared by interrupt status and mask
   localparam int EV_W = 4;
   localparam int EV_RX_BYTE = 0;
   localparam int EV_RX_DROP = 1;
   localparam int EV_FRAME_ERR = 2;
   localparam int EV_TX_DRAINED = 3;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // control bits
   localparam int CTRL_RX_EN = 0;
   localparam int CTRL_TX_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

endpackage : bur_pkg

// ### verilog/bur_byte_if.sv
// ----------------------------------------
// byte link between the uart core and its serial engines
// ----------------------------------------
interface bur_byte_if;
   logic [7:0] data;
   logic valid;
   logic ready;
   logic flag;
   modport src (output data, output valid, output flag, input ready);
   modport snk (input data, input valid, input flag, output ready);
endinterface : bur_byte_if

// ### verilog/bur_rx.sv
module bur_rx #(
   parameter int clock_frequency_param = bur_pkg::CLOCK_HZ_DEFAULT,
   parameter int baud_rate = bur_pkg::BAUD_DEFAULT
) (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   input logic ce,
   // filtered serial line
   input logic line,
   // received byte, pulsed valid, flag is the stop error
   bur_byte_if.src link
);

   localparam int BIT_TICKS = clock_frequency_param / baud_rate;
   localparam int CW = $clog2(BIT_TICKS + 1);
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_TICKS - 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(BIT_TICKS / 2 - 1);

   typedef struct packed {
      bur_pkg::bur_phase_t phase;
      logic [CW-1:0] cnt;
      logic [2:0] idx;
      logic [7:0] shift;
      logic [7:0] data;
      logic valid;
      logic err;
   } bur_rx_state_t;

   localparam bur_rx_state_t RST = '{phase: bur_pkg::BUR_IDLE, default: '0};

   bur_rx_state_t q;
   bur_rx_state_t n;

   assign link.data = q.data;
   assign link.valid = q.valid;
   assign link.flag = q.err;

   // ----------------------------------------
   // receive sequence
   // ----------------------------------------
   // counters only count down to zero, so any power-up value drains away
   always_comb begin
      n = q;
      n.valid = 1'b0;
      if (q.cnt != '0) begin
         n.cnt = q.cnt - CW'(1);
      end
      unique case (q.phase)
         bur_pkg::BUR_IDLE: begin
            if (line == bur_pkg::LINE_START) begin
               n.phase = bur_pkg::BUR_START;
               n.cnt = HALF_LAST;
            end
         end
         bur_pkg::BUR_START: begin
            if (q.cnt == '0) begin
               // a start bit gone by mid bit was a glitch
               n.phase = (line == bur_pkg::LINE_START) ? bur_pkg::BUR_DATA : bur_pkg::BUR_IDLE;
               n.cnt = BIT_LAST;
               n.idx = '0;
            end
         end
         bur_pkg::BUR_DATA: begin
            if (q.cnt == '0) begin
               n.shift = {line, q.shift[7:1]};
               n.cnt = BIT_LAST;
               n.idx = q.idx + 3'h1;
               if (q.idx == bur_pkg::LAST_BIT) begin
                  n.phase = bur_pkg::BUR_STOP;
               end
            end
         end
         bur_pkg::BUR_STOP: begin
            if (q.cnt == '0) begin
               n.data = q.shift;
               n.valid = 1'b1;
               n.err = (line != bur_pkg::LINE_IDLE);
               n.phase = bur_pkg::BUR_IDLE;
            end
         end
         default: begin
            n.phase = bur_pkg::BUR_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else if (ce) begin
         q <= n;
      end
   end

   AST_RX_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.valid && ce) |=> !q.valid)
      else $error("receive valid lasted more than one cycle");

   AST_RX_STOP_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.phase == bur_pkg::BUR_STOP && q.cnt == '0 && ce) |=> (q.valid && q.err == !$past(line)))
      else $error("stop error does not follow the sampled stop bit");

endmodule : bur_rx

// ### verilog/bur_tx.sv
module bur_tx #(
   parameter int clock_frequency_param = bur_pkg::CLOCK_HZ_DEFAULT,
   parameter int baud_rate = bur_pkg::BAUD_DEFAULT
) (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   input logic ce,
   // byte to send
   bur_byte_if.snk link,
   // serial line
   output logic txd
);

   localparam int BIT_TICKS = clock_frequency_param / baud_rate;
   localparam int CW = $clog2(BIT_TICKS + 1);
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_TICKS - 1);

   typedef struct packed {
      bur_pkg::bur_phase_t phase;
      logic [CW-1:0] cnt;
      logic [2:0] idx;
      logic [7:0] shift;
      logic line;
   } bur_tx_state_t;

   localparam bur_tx_state_t RST = '{phase: bur_pkg::BUR_IDLE, line: bur_pkg::LINE_IDLE, default: '0};

   bur_tx_state_t q;
   bur_tx_state_t n;

   assign link.ready = (q.phase == bur_pkg::BUR_IDLE);
   assign txd = q.line;

   // ----------------------------------------
   // transmit sequence
   // ----------------------------------------
   always_comb begin
      n = q;
      if (q.cnt != '0) begin
         n.cnt = q.cnt - CW'(1);
      end
      unique case (q.phase)
         bur_pkg::BUR_IDLE: begin
            n.line = bur_pkg::LINE_IDLE;
            if (link.valid) begin
               n.phase = bur_pkg::BUR_START;
               n.shift = link.data;
               n.line = bur_pkg::LINE_START;
               n.cnt = BIT_LAST;
            end
         end
         bur_pkg::BUR_START: begin
            if (q.cnt == '0) begin
               n.phase = bur_pkg::BUR_DATA;
               n.line = q.shift[0];
               n.idx = '0;
               n.cnt = BIT_LAST;
            end
         end
         bur_pkg::BUR_DATA: begin
            if (q.cnt == '0) begin
               n.cnt = BIT_LAST;
               if (q.idx == bur_pkg::LAST_BIT) begin
                  n.phase = bur_pkg::BUR_STOP;
                  n.line = bur_pkg::LINE_IDLE;
               end else begin
                  n.idx = q.idx + 3'h1;
                  n.shift = {1'b0, q.shift[7:1]};
                  n.line = q.shift[1];
               end
            end
         end
         bur_pkg::BUR_STOP: begin
            if (q.cnt == '0) begin
               n.phase = bur_pkg::BUR_IDLE;
            end
         end
         default: begin
            n.phase = bur_pkg::BUR_IDLE;
            n.line = bur_pkg::LINE_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else if (ce) begin
         q <= n;
      end
   end

   AST_TX_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
      (link.valid && link.ready && ce) |=> !link.ready [*8])
      else $error("transmitter ready returned during a character");

   AST_TX_START: assert property (@(posedge aclk) disable iff (!aresetn)
      (link.valid && link.ready && ce) |=> (txd == bur_pkg::LINE_START))
      else $error("start bit missing after accept");

   AST_TX_IDLE_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
      link.ready |-> txd)
      else $error("idle line not high");

endmodule : bur_tx

// ### verilog/bur_top.sv
// Behaviour
// - eight data bits, one stop, no parity
// - bit period is clock over baud
// - bytes move only when valid and ready
// - buffers hold one less than depth
// - separate buffer depths, default 2048 each
// - bytes stay buffered until sent or taken
// - stop error high when stop bit low
// - receiver valid is a one-cycle pulse
// - transmitter ready low while character runs
// - serial engine counters work without an initial reset
module bur_top #(
   parameter int clock_frequency_param = bur_pkg::CLOCK_HZ_DEFAULT,
   parameter int baud_rate = bur_pkg::BAUD_DEFAULT,
   parameter int rx_fifo_ram_depth = bur_pkg::FIFO_DEPTH_DEFAULT,
   parameter int tx_fifo_ram_depth = bur_pkg::FIFO_DEPTH_DEFAULT
) (
   // clock, reset, enable
   input logic aclk,
   input logic aresetn,
   input logic ce,
   // serial lines
   input logic rx,
   output logic tx,
   // receive byte stream
   output logic [7:0] recv_tdata,
   output logic recv_tvalid,
   input logic recv_tready,
   // send byte stream
   input logic [7:0] send_tdata,
   input logic send_tvalid,
   output logic send_tready,
   // receive status and interrupt
   output logic rx_fifo_full,
   output logic rx_stop_bit_error,
   output logic irq,
   // register bus
   input logic [bur_pkg::ADDR_W-1:0] s_axil_awaddr,
   input logic s_axil_awvalid,
   output logic s_axil_awready,
   input logic [31:0] s_axil_wdata,
   input logic [3:0] s_axil_wstrb,
   input logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input logic s_axil_bready,
   input logic [bur_pkg::ADDR_W-1:0] s_axil_araddr,
   input logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input logic s_axil_rready
);

   localparam int RAW = $clog2(rx_fifo_ram_depth);
   localparam int TAW = $clog2(tx_fifo_ram_depth);
   localparam logic [RAW-1:0] RX_MAX = RAW'(rx_fifo_ram_depth - 1);
   localparam logic [TAW-1:0] TX_MAX = TAW'(tx_fifo_ram_depth - 1);
   localparam logic [RAW-1:0] RX_ONE = RAW'(1);
   localparam logic [TAW-1:0] TX_ONE = TAW'(1);

   typedef struct packed {
      logic [2:0] sync;
      logic line;
      logic [RAW-1:0] rx_count;
      logic [RAW-1:0] rx_wr;
      logic [RAW-1:0] rx_rd;
      logic recv_valid;
      logic [7:0] recv_data;
      logic [TAW-1:0] tx_count;
      logic [TAW-1:0] tx_wr;
      logic [TAW-1:0] tx_rd;
      logic stage_valid;
      logic [7:0] stage_data;
      logic [bur_pkg::EV_W-1:0] int_status;
      logic [bur_pkg::EV_W-1:0] int_mask;
      logic [1:0] ctrl;
      logic aw_got;
      logic [bur_pkg::ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bur_top_state_t;

   localparam bur_top_state_t RST = '{
      sync: 3'h7,
      line: bur_pkg::LINE_IDLE,
      int_mask: bur_pkg::MASK_RESET,
      ctrl: bur_pkg::CTRL_RESET,
      default: '0
   };

   bur_top_state_t q;
   bur_top_state_t n;

   // block ram style storage, kept out of the state record
   logic [7:0] rx_mem [rx_fifo_ram_depth];
   logic [7:0] tx_mem [tx_fifo_ram_depth];

   bur_byte_if rx_link ();
   bur_byte_if tx_link ();

   // ----------------------------------------
   // serial engines
   // ----------------------------------------
   bur_rx #(
      .clock_frequency_param(clock_frequency_param),
      .baud_rate(baud_rate)
   ) bur_rx_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .line(q.line),
      .link(rx_link)
   );

   bur_tx #(
      .clock_frequency_param(clock_frequency_param),
      .baud_rate(baud_rate)
   ) bur_tx_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .link(tx_link),
      .txd(tx)
   );

   // ----------------------------------------
   // buffer handshakes
   // ----------------------------------------
   logic rx_en;
   logic tx_en;
   logic rx_push;
   logic rx_drop;
   logic recv_take;
   logic rx_mem_has;
   logic rx_load;
   logic send_take;
   logic tx_take;
   logic tx_mem_has;
   logic tx_load;
   logic tx_drained;
   logic [bur_pkg::EV_W-1:0] events;

   assign rx_en = q.ctrl[bur_pkg::CTRL_RX_EN];
   assign tx_en = q.ctrl[bur_pkg::CTRL_TX_EN];
   assign rx_fifo_full = (q.rx_count == RX_MAX);
   // the receiver has no back-pressure, so the buffer must always listen
   assign rx_link.ready = 1'b1;
   assign rx_push = rx_link.valid && rx_en && !rx_fifo_full;
   assign rx_drop = rx_link.valid && rx_en && rx_fifo_full;
   assign recv_tvalid = q.recv_valid;
   assign recv_tdata = q.recv_data;
   assign recv_take = q.recv_valid && recv_tready;
   // the output register counts as a slot, so capacity stays depth minus one
   assign rx_mem_has = (q.rx_count != '0) && !(q.rx_count == RX_ONE && q.recv_valid);
   assign rx_load = rx_mem_has && (!q.recv_valid || recv_take);
   assign rx_stop_bit_error = rx_link.flag;

   assign send_tready = (q.tx_count != TX_MAX);
   assign send_take = send_tvalid && send_tready;
   // clearing the enable pauses the next character, never the current one
   assign tx_link.valid = q.stage_valid && tx_en;
   assign tx_link.data = q.stage_data;
   assign tx_link.flag = 1'b0;
   assign tx_take = tx_link.valid && tx_link.ready;
   assign tx_mem_has = (q.tx_count != '0) && !(q.tx_count == TX_ONE && q.stage_valid);
   assign tx_load = tx_mem_has && (!q.stage_valid || tx_take);
   assign tx_drained = tx_take && (q.tx_count == TX_ONE) && !send_take;

   always_comb begin
      events = '0;
      events[bur_pkg::EV_RX_BYTE] = rx_push;
      events[bur_pkg::EV_RX_DROP] = rx_drop;
      events[bur_pkg::EV_FRAME_ERR] = rx_link.valid && rx_link.flag;
      events[bur_pkg::EV_TX_DRAINED] = tx_drained;
   end

   assign irq = |(q.int_status & q.int_mask);

   // ----------------------------------------
   // register bus handshakes
   // ----------------------------------------
   assign s_axil_awready = !q.aw_got && !q.bvalid;
   assign s_axil_wready = !q.w_got && !q.bvalid;
   assign s_axil_bvalid = q.bvalid;
   assign s_axil_bresp = q.bresp;
   assign s_axil_arready = !q.rvalid;
   assign s_axil_rvalid = q.rvalid;
   assign s_axil_rdata = q.rdata;
   assign s_axil_rresp = q.rresp;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [bur_pkg::EV_W-1:0] clr;
      logic [31:0] rd;
      clr = '0;
      rd = '0;
      n = q;

      // three stage line filter
      n.sync = {q.sync[1:0], rx};
      if (q.sync[1] == q.sync[2]) begin
         n.line = q.sync[2];
      end

      // receive buffer
      if (rx_push) begin
         n.rx_wr = (q.rx_wr == RX_MAX) ? '0 : q.rx_wr + RX_ONE;
      end
      if (rx_load) begin
         n.recv_data = rx_mem[q.rx_rd];
         n.recv_valid = 1'b1;
         n.rx_rd = (q.rx_rd == RX_MAX) ? '0 : q.rx_rd + RX_ONE;
      end else if (recv_take) begin
         n.recv_valid = 1'b0;
      end
      n.rx_count = q.rx_count + RAW'(rx_push) - RAW'(recv_take);

      // transmit buffer
      if (send_take) begin
         n.tx_wr = (q.tx_wr == TX_MAX) ? '0 : q.tx_wr + TX_ONE;
      end
      if (tx_load) begin
         n.stage_data = tx_mem[q.tx_rd];
         n.stage_valid = 1'b1;
         n.tx_rd = (q.tx_rd == TX_MAX) ? '0 : q.tx_rd + TX_ONE;
      end else if (tx_take) begin
         n.stage_valid = 1'b0;
      end
      n.tx_count = q.tx_count + TAW'(send_take) - TAW'(tx_take);

      // write channel, address and data in either order
      if (s_axil_awvalid && s_axil_awready) begin
         n.aw_got = 1'b1;
         n.aw_addr = s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
         n.w_got = 1'b1;
         n.w_data = s_axil_wdata;
         n.w_strb = s_axil_wstrb;
      end
      if (q.aw_got && q.w_got) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = bur_pkg::RESP_OKAY;
         case (q.aw_addr)
            bur_pkg::REG_STATUS: begin
            end
            bur_pkg::REG_INT_STATUS: begin
               if (q.w_strb[0]) begin
                  clr = q.w_data[bur_pkg::EV_W-1:0];
               end
            end
            bur_pkg::REG_INT_MASK: begin
               if (q.w_strb[0]) begin
                  n.int_mask = q.w_data[bur_pkg::EV_W-1:0];
               end
            end
            bur_pkg::REG_CTRL: begin
               if (q.w_strb[0]) begin
                  n.ctrl = q.w_data[1:0];
               end
            end
            default: begin
               n.bresp = bur_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (q.bvalid && s_axil_bready) begin
         n.bvalid = 1'b0;
      end

      // a new event wins over a clear in the same cycle
      n.int_status = (q.int_status & ~clr) | events;

      // read channel
      if (s_axil_arvalid && s_axil_arready) begin
         n.rvalid = 1'b1;
         n.rresp = bur_pkg::RESP_OKAY;
         case (s_axil_araddr)
            bur_pkg::REG_STATUS: begin
               rd[bur_pkg::ST_RX_FULL] = rx_fifo_full;
               rd[bur_pkg::ST_STOP_ERR] = rx_link.flag;
               rd[bur_pkg::ST_RX_AVAIL] = q.recv_valid;
               rd[bur_pkg::ST_TX_EMPTY] = (q.tx_count == '0);
               rd[bur_pkg::ST_TX_BUSY] = !tx_link.ready;
            end
            bur_pkg::REG_INT_STATUS: begin
               rd[bur_pkg::EV_W-1:0] = q.int_status;
            end
            bur_pkg::REG_INT_MASK: begin
               rd[bur_pkg::EV_W-1:0] = q.int_mask;
            end
            bur_pkg::REG_CTRL: begin
               rd[1:0] = q.ctrl;
            end
            default: begin
               n.rresp = bur_pkg::RESP_SLVERR;
            end
         endcase
         n.rdata = rd;
      end else if (q.rvalid && s_axil_rready) begin
         n.rvalid = 1'b0;
      end
   end

   // ----------------------------------------
   // registers and storage
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else if (ce) begin
         q <= n;
      end
   end

   always_ff @(posedge aclk) begin
      if (ce && rx_push) begin
         rx_mem[q.rx_wr] <= rx_link.data;
      end
      if (ce && send_take) begin
         tx_mem[q.tx_wr] <= send_tdata;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_RX_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
      q.rx_count <= RX_MAX)
      else $error("receive buffer above capacity");

   AST_TX_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
      q.tx_count <= TX_MAX)
      else $error("transmit buffer above capacity");

   AST_RX_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
      (rx_fifo_full && rx_link.valid && !recv_take && ce) |=> (q.rx_count == $past(q.rx_count)))
      else $error("byte stored while receive buffer full");

   AST_RECV_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      (recv_tvalid && !recv_tready && ce) |=> (recv_tvalid && $stable(recv_tdata)))
      else $error("received byte lost before it was taken");

   AST_SEND_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
      (send_take && !tx_take && ce) |=> (q.tx_count == $past(q.tx_count) + TX_ONE))
      else $error("accepted send byte not counted");

endmodule : bur_top

// ### test/bur_peer.sv
// remote serial device: drives rx, watches tx
module bur_peer #(
   parameter int bit_len = 16
) (
   input wire logic aclk,
   input wire logic tx,
   output logic rx
);
   timeunit 1ns;
   timeprecision 100ps;

   initial rx = 1'b1;

   // start, data lsb first, stop, then an idle bit
   task automatic send(input logic [7:0] b, input logic stop);
      logic [10:0] f;
      f = {1'b1, stop, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge aclk);
         rx <= f[i];
         repeat (bit_len - 1) @(posedge aclk);
      end
   endtask : send

   // samples mid bit; returns {stop, data, start}
   task automatic recv(output logic [9:0] f);
      while (tx !== 1'b0) @(posedge aclk);
      repeat (bit_len / 2) @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         if (i > 0) repeat (bit_len) @(posedge aclk);
         f[i] = tx;
      end
   endtask : recv
endmodule : bur_peer

// ### test/bur_top_tb.sv
module bur_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BL = 16;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic rx, tx, irq, rx_fifo_full, rx_stop_bit_error;
   logic [7:0] recv_tdata, send_tdata = 8'h00, s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
   logic recv_tvalid, send_tready, recv_tready = 1'b0, send_tvalid = 1'b0;
   logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
   logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, ce = 1'b1;
   logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, d;
   logic [3:0] s_axil_wstrb = 4'h0;
   logic [1:0] s_axil_bresp, s_axil_rresp, rs;
   logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
   logic [9:0] f1, f2;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;

   always #50 aclk = ~aclk;

   bur_top #(.clock_frequency_param(BL), .baud_rate(1), .rx_fifo_ram_depth(8), .tx_fifo_ram_depth(8)) bur_top_i (
      .aclk, .aresetn, .ce(ce), .rx, .tx, .recv_tdata, .recv_tvalid, .recv_tready,
      .send_tdata, .send_tvalid, .send_tready, .rx_fifo_full, .rx_stop_bit_error, .irq,
      .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
      .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
      .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
      .s_axil_rvalid, .s_axil_rready);
   bur_peer #(.bit_len(BL)) bur_peer_i (.aclk, .tx, .rx);

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axil_awaddr <= a;
      s_axil_wdata <= v;
      s_axil_wstrb <= 4'hf;
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axil_awready) s_axil_awvalid <= 1'b0;
         if (s_axil_wready) s_axil_wvalid <= 1'b0;
      end while (s_axil_bvalid !== 1'b1);
      s_axil_bready <= 1'b0;
      rs = s_axil_bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axil_arready) s_axil_arvalid <= 1'b0;
      end while (s_axil_rvalid !== 1'b1);
      s_axil_rready <= 1'b0;
      d = s_axil_rdata;
      rs = s_axil_rresp;
   endtask : rd

   task automatic push(input logic [7:0] b);
      @(posedge aclk);
      send_tdata <= b;
      send_tvalid <= 1'b1;
      do @(posedge aclk); while (send_tready !== 1'b1);
      send_tvalid <= 1'b0;
   endtask : push

   task automatic take(input logic [7:0] e);
      @(posedge aclk);
      recv_tready <= 1'b1;
      do @(posedge aclk); while (recv_tvalid !== 1'b1);
      chk(recv_tdata, e);
      recv_tready <= 1'b0;
   endtask : take

   task automatic conclude;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   // generous: whole run is near 2400 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({tx, send_tready, recv_tvalid, rx_fifo_full, irq}, 5'b11000);
      // frozen engine must not see a frame
      ce <= 1'b0;
      bur_peer_i.send(8'h3c, 1'b1);
      ce <= 1'b1;
      repeat (30) @(posedge aclk);
      chk({recv_tvalid, tx}, 2'b01);
      bur_peer_i.send(8'h3c, 1'b1);
      take(8'h3c);
      chk(rx_stop_bit_error, 1'b0);
      chk(irq, 1'b0);
      wr(bur_pkg::REG_INT_MASK, 32'h1);
      chk(rs, bur_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      rd(bur_pkg::REG_INT_STATUS);
      chk(d[0], 1'b1);
      chk(rs, bur_pkg::RESP_OKAY);
      wr(bur_pkg::REG_INT_STATUS, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      rd(8'h40);
      chk(rs, bur_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h40, 32'h1);
      chk(rs, bur_pkg::RESP_SLVERR);
      bur_peer_i.send(8'h81, 1'b0);
      take(8'h81);
      chk(rx_stop_bit_error, 1'b1);
      // consumer stalls; eighth byte finds the buffer full
      for (int i = 0; i < 8; i++) begin
         bur_peer_i.send(8'(i) + 8'h10, 1'b1);
         chk(rx_fifo_full, i >= 6);
      end
      rd(bur_pkg::REG_STATUS);
      chk(d[0], 1'b1);
      rd(bur_pkg::REG_INT_STATUS);
      chk(d[3:0], 4'h7);
      for (int i = 0; i < 7; i++) take(8'(i) + 8'h10);
      repeat (2) @(posedge aclk);
      chk({recv_tvalid, rx_stop_bit_error}, 2'b00);
      fork
         begin
            push(8'ha5);
            push(8'h5a);
         end
         begin
            bur_peer_i.recv(f1);
            bur_peer_i.recv(f2);
         end
      join
      chk(f1, {1'b1, 8'ha5, 1'b0});
      chk(f2, {1'b1, 8'h5a, 1'b0});
      // transmitter held off, so the buffer only fills
      wr(bur_pkg::REG_CTRL, 32'h1);
      n = 0;
      send_tvalid <= 1'b1;
      repeat (20) begin
         @(posedge aclk);
         if (send_tready) n++;
      end
      send_tvalid <= 1'b0;
      chk(n, 7);
      chk(send_tready, 1'b0);
      rd(bur_pkg::REG_INT_STATUS);
      chk(d[3:0], 4'hf);
      conclude();
   end
endmodule : bur_top_tb
